/* core/ccu_capture_compare_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module ccu_capture_compare_unit
    import ccu_pkg::*;
(
    input wire logic ref_clk, // system clock, 100 MHz
    input wire logic arst_n, // async reset, active low
    input wire logic [2:0] module_id, // which module this instance is
    input wire logic [1:0] timer_three_control, // timer-to-module select bits
    input wire logic second_enhanced_pin_select, // 1 routes to port c bit one
    input wire logic mcu_mode, // 1 in microcontroller mode
    input wire logic ctrl_wr, // write strobe, module control register
    input wire logic [MODE_W-1:0] ctrl_wr_data, // new module_mode_select
    input wire logic value_wr_low, // write strobe, low value byte
    input wire logic value_wr_high, // write strobe, high value byte
    input wire logic [BYTE_W-1:0] value_wr_data, // byte to write
    input wire logic flag_clear, // software clears the flag
    input wire logic match_capture_irq_enable, // interrupt enable
    input wire logic [VAL_W-1:0] timer_one_count, // timer one count
    input wire logic [VAL_W-1:0] timer_three_count, // timer three count
    input wire logic timer_one_async, // timer one in async counter mode
    input wire logic timer_three_async, // timer three in async counter mode
    input wire logic own_pin_in, // pad level of this module's pin
    input wire logic port_c_bit_one_in, // pad level, port c bit one
    input wire logic port_e_bit_seven_in, // pad level, port e bit seven
    input wire logic port_e_bit_three_in, // pad level, port e bit three
    input wire logic port_latch, // port data latch of the pin
    input wire logic pin_direction_bit, // 1 = input, 0 = output
    output logic [MODE_W-1:0] module_mode_select, // control register readback
    output logic [BYTE_W-1:0] value_low_byte, // value register low byte
    output logic [BYTE_W-1:0] value_high_byte, // value register high byte
    output logic match_capture_flag, // sticky event flag
    output logic match_capture_irq, // flag gated by enable
    output logic pin_data_out, // level driven onto the pin
    output logic pin_oe_n, // pin output enable, low while driving
    output logic [2:0] pin_route, // one-hot route of module two
    output logic uses_timer_three, // cap/cmp time base is timer three
    output logic pwm_uses_timer_four, // pwm time base is timer four
    output logic timer_one_reset, // one-cycle pulse, clear timer one
    output logic timer_three_reset // one-cycle pulse, clear timer three
);
    logic [MODE_W-1:0] mode_q;
    logic [VAL_W-1:0] value_q;
    logic [PRE_W-1:0] pre_cnt_q;
    logic flag_q;
    logic cmp_latch_q;
    logic match_q;
    logic pin_raw;
    logic rise;
    logic fall;
    logic use_low;
    logic [VAL_W-1:0] sel_count;
    logic sel_async;
    logic is_capture;
    logic is_compare;
    logic cap_evt;
    logic cmp_evt;
    logic match;
    logic drives_latch;

    // timer assignment from the select bits and the module identity
    always_comb begin
        unique case (timer_three_control)
            TSEL_ALL_LOW: use_low = 1'b1;
            TSEL_ONE_LOW: use_low = (module_id == ID_ENH_ONE);
            TSEL_TWO_LOW: use_low = (module_id == ID_ENH_ONE) || (module_id == ID_ENH_TWO);
            TSEL_ALL_HIGH: use_low = 1'b0;
        endcase
    end

    // cap/cmp time base is timer one or three, never the pwm timers
    assign sel_count = use_low ? timer_one_count : timer_three_count;
    assign sel_async = use_low ? timer_one_async : timer_three_async;

    // static routing mux ahead of the synchroniser, so only one pad is sampled
    always_comb begin
        if (module_id != ID_ENH_TWO) begin
            pin_raw = own_pin_in;
        end else if (second_enhanced_pin_select) begin
            pin_raw = port_c_bit_one_in;
        end else if (mcu_mode) begin
            pin_raw = port_e_bit_seven_in;
        end else begin
            pin_raw = port_e_bit_three_in;
        end
    end

    // pad level is synchronised before any edge logic looks at it
    ccu_pin_sync u_sync (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .pin_async(pin_raw),
        .rise_q(rise),
        .fall_q(fall)
    );

    assign is_capture = (mode_q[3:2] == CLASS_CAPTURE);
    assign is_compare = (mode_q == MODE_CMP_TOGGLE) || (mode_q[3:2] == 2'h2);

    // qualifying capture event; the async timer mode blocks it entirely
    always_comb begin
        cap_evt = 1'b0;
        if (!sel_async) begin
            unique case (mode_q)
                MODE_CAP_FALL: cap_evt = fall;
                MODE_CAP_RISE: cap_evt = rise;
                MODE_CAP_RISE4: cap_evt = rise && (pre_cnt_q[1:0] == PRE4_LAST);
                MODE_CAP_RISE16: cap_evt = rise && (pre_cnt_q == PRE16_LAST);
                default: cap_evt = 1'b0;
            endcase
        end
    end

    // compare runs every cycle; only the first cycle of a match counts,
    // since a slow timer may hold the matching count for many clocks
    assign match = is_compare && !sel_async && (sel_count == value_q);
    assign cmp_evt = match && !match_q;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            match_q <= 1'b0;
        end else begin
            match_q <= match;
        end
    end

    // control register; value zero is the off state
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            mode_q <= MODE_OFF;
        end else if (ctrl_wr) begin
            mode_q <= ctrl_wr_data;
        end
    end

    // prescaler counts rising edges; a direct prescale switch keeps the
    // count, so the first capture after it may come early
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_cnt_q <= PRE_RESET;
        end else if (!is_capture) begin
            pre_cnt_q <= PRE_RESET;
        end else if (rise) begin
            pre_cnt_q <= pre_cnt_q + 4'h1;
        end
    end

    // value pair; a capture wins over a software write in the same cycle
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            value_q <= VAL_RESET;
        end else if (cap_evt) begin
            value_q <= sel_count;
        end else begin
            if (value_wr_low) begin
                value_q[BYTE_W-1:0] <= value_wr_data;
            end
            if (value_wr_high) begin
                value_q[VAL_W-1:BYTE_W] <= value_wr_data;
            end
        end
    end

    // sticky flag: set beats clear when both land together
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= (flag_q && !flag_clear) || cap_evt || cmp_evt;
        end
    end

    // compare output latch, separate from the port data latch
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmp_latch_q <= 1'b0;
        end else if (ctrl_wr) begin
            unique case (ctrl_wr_data)
                MODE_OFF: cmp_latch_q <= 1'b0;
                MODE_CMP_SET_HIGH: cmp_latch_q <= 1'b0;
                MODE_CMP_SET_LOW: cmp_latch_q <= 1'b1;
                default: cmp_latch_q <= cmp_latch_q;
            endcase
        end else if (cmp_evt) begin
            unique case (mode_q)
                MODE_CMP_TOGGLE: cmp_latch_q <= !cmp_latch_q;
                MODE_CMP_SET_HIGH: cmp_latch_q <= 1'b1;
                MODE_CMP_SET_LOW: cmp_latch_q <= 1'b0;
                default: cmp_latch_q <= cmp_latch_q;
            endcase
        end
    end

    // pin shows the compare latch only in the pin-driving compare modes
    assign drives_latch = (mode_q == MODE_CMP_TOGGLE) || (mode_q == MODE_CMP_SET_HIGH)
        || (mode_q == MODE_CMP_SET_LOW);

    // pin outputs; direction stays software's, so a driven pin may still
    // be seen by the capture logic through the pad
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_data_out <= 1'b0;
            pin_oe_n <= 1'b1;
        end else begin
            pin_data_out <= drives_latch ? cmp_latch_q : port_latch;
            pin_oe_n <= pin_direction_bit;
        end
    end

    // special event trigger clears whichever timer serves this module
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            timer_one_reset <= 1'b0;
            timer_three_reset <= 1'b0;
        end else begin
            timer_one_reset <= cmp_evt && (mode_q == MODE_CMP_SPECIAL) && use_low;
            timer_three_reset <= cmp_evt && (mode_q == MODE_CMP_SPECIAL) && !use_low;
        end
    end

    // timer selection and routing seen by the timers and the port logic
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            uses_timer_three <= 1'b0;
            pwm_uses_timer_four <= 1'b0;
            pin_route <= ROUTE_NONE;
        end else begin
            uses_timer_three <= !use_low;
            pwm_uses_timer_four <= !use_low;
            pin_route <= ROUTE_NONE;
            if (module_id == ID_ENH_TWO) begin
                pin_route[ROUTE_C1] <= second_enhanced_pin_select;
                pin_route[ROUTE_E7] <= !second_enhanced_pin_select && mcu_mode;
                pin_route[ROUTE_E3] <= !second_enhanced_pin_select && !mcu_mode;
            end
        end
    end

    // register readback and gated interrupt
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            match_capture_irq <= 1'b0;
        end else begin
            match_capture_irq <= flag_q && match_capture_irq_enable;
        end
    end

    assign module_mode_select = mode_q;
    assign value_low_byte = value_q[BYTE_W-1:0];
    assign value_high_byte = value_q[VAL_W-1:BYTE_W];
    assign match_capture_flag = flag_q;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);

    property p_flag_sticky;
        flag_q && !flag_clear |=> flag_q;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag lost");

    property p_capture_load;
        cap_evt |=> (value_q == $past(sel_count)) && flag_q;
    endproperty
    a_capture_load: assert property (p_capture_load) else $error("capture not loaded");

    // watched at the flag, so a leak through either event path shows up
    property p_async_no_capture;
        sel_async && !flag_q |=> !flag_q;
    endproperty
    a_async_no_capture: assert property (p_async_no_capture) else $error("event in async mode");

    property p_prescale_clear;
        !is_capture |=> pre_cnt_q == PRE_RESET;
    endproperty
    a_prescale_clear: assert property (p_prescale_clear) else $error("prescaler not cleared");

    property p_every_fourth;
        (mode_q == MODE_CAP_RISE4) && rise && (pre_cnt_q[1:0] != PRE4_LAST) |-> !cap_evt;
    endproperty
    a_every_fourth: assert property (p_every_fourth) else $error("early 4th capture");

    property p_set_high;
        cmp_evt && !ctrl_wr && (mode_q == MODE_CMP_SET_HIGH) |=> cmp_latch_q ##1 pin_data_out;
    endproperty
    a_set_high: assert property (p_set_high) else $error("pin not driven high");

    property p_toggle;
        cmp_evt && !ctrl_wr && (mode_q == MODE_CMP_TOGGLE) |=> cmp_latch_q != $past(cmp_latch_q);
    endproperty
    a_toggle: assert property (p_toggle) else $error("no toggle");

    property p_off_low;
        ctrl_wr && (ctrl_wr_data == MODE_OFF) |=> !cmp_latch_q;
    endproperty
    a_off_low: assert property (p_off_low) else $error("latch not forced low");

    property p_soft_irq_pin;
        (mode_q == MODE_CMP_SOFT_IRQ) |=> pin_data_out == $past(port_latch);
    endproperty
    a_soft_irq_pin: assert property (p_soft_irq_pin) else $error("pin touched in 1010");

    property p_special;
        cmp_evt && (mode_q == MODE_CMP_SPECIAL) |=> timer_one_reset || timer_three_reset;
    endproperty
    a_special: assert property (p_special) else $error("no timer reset");

    property p_setting_two;
        (timer_three_control == TSEL_ONE_LOW) && (module_id != ID_ENH_ONE) |=> uses_timer_three;
    endproperty
    a_setting_two: assert property (p_setting_two) else $error("wrong timer");

    property p_match_flag;
        cmp_evt |=> flag_q;
    endproperty
    a_match_flag: assert property (p_match_flag) else $error("match flag not set");

    property p_irq_gate;
        !match_capture_irq_enable |=> !match_capture_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enable");
endmodule
`default_nettype wire

/* core/ccu_pkg.sv */
package ccu_pkg;
    localparam int VAL_W = 16;
    localparam int BYTE_W = 8;
    localparam int MODE_W = 4;
    localparam int PRE_W = 4;

    // mode select encodings held in the module control register
    typedef enum logic [MODE_W-1:0] {
        MODE_OFF = 4'h0,
        MODE_CMP_TOGGLE = 4'h2,
        MODE_CAP_FALL = 4'h4,
        MODE_CAP_RISE = 4'h5,
        MODE_CAP_RISE4 = 4'h6,
        MODE_CAP_RISE16 = 4'h7,
        MODE_CMP_SET_HIGH = 4'h8,
        MODE_CMP_SET_LOW = 4'h9,
        MODE_CMP_SOFT_IRQ = 4'hA,
        MODE_CMP_SPECIAL = 4'hB
    } ccu_mode_type;

    // upper two mode bits give the mode class
    localparam logic [1:0] CLASS_CAPTURE = 2'h1;
    localparam logic [1:0] CLASS_PWM = 2'h3;

    // prescaler terminal counts
    localparam logic [1:0] PRE4_LAST = 2'h3;
    localparam logic [PRE_W-1:0] PRE16_LAST = 4'hF;
    localparam logic [PRE_W-1:0] PRE_RESET = 4'h0;

    // timer-to-module assignment settings
    localparam logic [1:0] TSEL_ALL_LOW = 2'h0;
    localparam logic [1:0] TSEL_ONE_LOW = 2'h1;
    localparam logic [1:0] TSEL_TWO_LOW = 2'h2;
    localparam logic [1:0] TSEL_ALL_HIGH = 2'h3;

    // module identities
    localparam logic [2:0] ID_ENH_ONE = 3'h0;
    localparam logic [2:0] ID_ENH_TWO = 3'h1;

    // one-hot pin route bits of the second enhanced module
    localparam int ROUTE_C1 = 0;
    localparam int ROUTE_E7 = 1;
    localparam int ROUTE_E3 = 2;
    localparam logic [2:0] ROUTE_NONE = 3'h0;

    localparam logic [VAL_W-1:0] VAL_RESET = 16'h0000;
endpackage

/* core/ccu_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module ccu_pin_sync
    import ccu_pkg::*;
(
    input wire logic ref_clk, // system clock
    input wire logic arst_n, // async reset, active low
    input wire logic pin_async, // raw pin level
    output logic rise_q, // one-cycle pulse, rising edge seen
    output logic fall_q // one-cycle pulse, falling edge seen
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // two-stage synchroniser; only sync_q reads meta_q
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= pin_async;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end

    // registered edge pulses, so the capture lands one clock later
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rise_q <= 1'b0;
            fall_q <= 1'b0;
        end else begin
            rise_q <= sync_q & ~last_q;
            fall_q <= ~sync_q & last_q;
        end
    end
endmodule
`default_nettype wire

/* verification/ccu_timer_model.sv */
`timescale 1ns/1ps
`default_nettype none
// timer as the unit sees it; it holds still so captured values are exact
module ccu_timer_model
    import ccu_pkg::*;
(
    input wire logic ref_clk, // system clock
    input wire logic arst_n, // async reset, active low
    input wire logic load, // load strobe from the bench
    input wire logic [VAL_W-1:0] load_val, // value to load
    input wire logic clear_pulse, // special event clear from the unit
    output logic [VAL_W-1:0] count_q // current count
);
    // clear wins over load so a trigger is never hidden by bench traffic
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_q <= VAL_RESET;
        end else if (clear_pulse) begin
            count_q <= VAL_RESET;
        end else if (load) begin
            count_q <= load_val;
        end
    end
endmodule
`default_nettype wire

/* verification/capture_compare_unit_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module capture_compare_unit_tb_top
    import ccu_pkg::*;
;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [2:0] module_id = 3'h2;
    logic [1:0] tsel = 2'h0;
    logic pin_sel = 1'b1;
    logic mcu_mode = 1'b0;
    logic ctrl_wr = 1'b0;
    logic [MODE_W-1:0] ctrl_data = 4'h0;
    logic wr_lo = 1'b0;
    logic wr_hi = 1'b0;
    logic [BYTE_W-1:0] wr_byte = 8'h00;
    logic flag_clear = 1'b0;
    logic irq_en = 1'b0;
    logic t1_async = 1'b0;
    logic t3_async = 1'b0;
    logic pad = 1'b0;
    logic port_latch = 1'b0;
    logic dir = 1'b1;
    logic t1_load = 1'b0;
    logic t3_load = 1'b0;
    logic [VAL_W-1:0] t_val = 16'h0000;
    logic [VAL_W-1:0] t1_count;
    logic [VAL_W-1:0] t3_count;
    logic [MODE_W-1:0] mode_rb;
    logic [BYTE_W-1:0] lo_b;
    logic [BYTE_W-1:0] hi_b;
    logic flag;
    logic irq;
    logic pin_out;
    logic oe_n;
    logic [2:0] route;
    logic use3;
    logic use4;
    logic t1_clr;
    logic t3_clr;
    int fails = 0;
    int checks_done = 0;

    // the unit, with every pad fed from one bench level
    ccu_capture_compare_unit i_ccu_capture_compare_unit (.ref_clk(ref_clk), .arst_n(arst_n),
        .module_id(module_id), .timer_three_control(tsel), .second_enhanced_pin_select(pin_sel),
        .mcu_mode(mcu_mode), .ctrl_wr(ctrl_wr), .ctrl_wr_data(ctrl_data), .value_wr_low(wr_lo),
        .value_wr_high(wr_hi), .value_wr_data(wr_byte), .flag_clear(flag_clear),
        .match_capture_irq_enable(irq_en), .timer_one_count(t1_count), .timer_three_count(t3_count),
        .timer_one_async(t1_async), .timer_three_async(t3_async), .own_pin_in(pad),
        .port_c_bit_one_in(pad), .port_e_bit_seven_in(pad), .port_e_bit_three_in(pad),
        .port_latch(port_latch), .pin_direction_bit(dir), .module_mode_select(mode_rb),
        .value_low_byte(lo_b), .value_high_byte(hi_b), .match_capture_flag(flag),
        .match_capture_irq(irq), .pin_data_out(pin_out), .pin_oe_n(oe_n), .pin_route(route),
        .uses_timer_three(use3), .pwm_uses_timer_four(use4), .timer_one_reset(t1_clr),
        .timer_three_reset(t3_clr));
    // both time bases on the far side
    ccu_timer_model i_timer_one (.ref_clk(ref_clk), .arst_n(arst_n), .load(t1_load), .load_val(t_val),
        .clear_pulse(t1_clr), .count_q(t1_count));
    ccu_timer_model i_timer_three (.ref_clk(ref_clk), .arst_n(arst_n), .load(t3_load), .load_val(t_val),
        .clear_pulse(t3_clr), .count_q(t3_count));

    // 100 mhz clock
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    task automatic chk_bit(input string what, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic chk_val(input string what, input logic [VAL_W-1:0] exp, input logic [VAL_W-1:0] got);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wr_ctrl(input logic [MODE_W-1:0] m);
        ctrl_data = m;
        ctrl_wr = 1'b1;
        tick(1);
        ctrl_wr = 1'b0;
        tick(1);
    endtask

    // one shared data bus, so the two bytes go in separate cycles
    task automatic wr_val(input logic [VAL_W-1:0] v);
        wr_byte = v[7:0];
        wr_lo = 1'b1;
        tick(1);
        wr_lo = 1'b0;
        wr_byte = v[15:8];
        wr_hi = 1'b1;
        tick(1);
        wr_hi = 1'b0;
        tick(1);
    endtask

    task automatic set_timer(input logic three, input logic [VAL_W-1:0] v);
        t_val = v;
        t1_load = !three;
        t3_load = three;
        tick(1);
        t1_load = 1'b0;
        t3_load = 1'b0;
        tick(1);
    endtask

    // pad level held long enough to pass the synchroniser
    task automatic pad_to(input logic l);
        pad = l;
        tick(6);
    endtask

    task automatic clr_flag();
        flag_clear = 1'b1;
        tick(1);
        flag_clear = 1'b0;
        tick(1);
    endtask

    // the timer ends off the value so the next mode write sees no match
    task automatic cmp_hit(input logic [VAL_W-1:0] v);
        set_timer(1'b0, v);
        tick(3);
        set_timer(1'b0, v ^ 16'h0001);
    endtask

    task automatic give_verdict();
        if (fails == 0 && checks_done > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // the tests need about 450 cycles; the 15000-cycle limit, over thirty times that, means a hang
    initial begin
        #150000;
        fails++;
        give_verdict();
    end

    initial begin
        logic exp3;
        logic [MODE_W-1:0] pre_mode [2];
        int pre_n [2];
        logic [MODE_W-1:0] cmp_mode [2];
        pre_mode = '{MODE_CAP_RISE4, MODE_CAP_RISE16};
        pre_n = '{4, 16};
        cmp_mode = '{MODE_CMP_SET_HIGH, MODE_CMP_SET_LOW};
        tick(20);
        arst_n = 1'b1;
        tick(2);
        chk_val("value", VAL_RESET, {hi_b, lo_b});
        chk_val("mode", 16'h0000, {12'h000, mode_rb});
        chk_bit("flag", 1'b0, flag);
        chk_bit("pin_oe_n", 1'b1, oe_n);
        for (int s = 0; s < 4; s++) begin
            for (int id = 0; id < 3; id++) begin
                tsel = s[1:0];
                module_id = id[2:0];
                tick(2);
                exp3 = (s == 3) || (s == 1 && id != 0) || (s == 2 && id == 2);
                chk_bit("uses_timer_three", exp3, use3);
                chk_bit("pwm_uses_timer_four", exp3, use4);
            end
        end
        module_id = ID_ENH_TWO;
        for (int k = 0; k < 3; k++) begin
            pin_sel = (k == 0);
            mcu_mode = (k == 1);
            tick(2);
            chk_val("pin_route", {13'h0000, 3'h1 << k}, {13'h0000, route});
        end
        module_id = 3'h2;
        tick(2);
        chk_val("pin_route", 16'h0000, {13'h0000, route});
        // capture from timer three, latency window, overwrite and sticky flag
        tsel = TSEL_ALL_HIGH;
        set_timer(1'b0, 16'hAAAA);
        set_timer(1'b1, 16'h1234);
        wr_val(16'hBEEF);
        chk_val("value", 16'hBEEF, {hi_b, lo_b});
        wr_ctrl(MODE_CAP_RISE);
        chk_val("mode", 16'h0005, {12'h000, mode_rb});
        irq_en = 1'b1;
        pad = 1'b1;
        tick(2);
        chk_val("value", 16'hBEEF, {hi_b, lo_b});
        tick(4);
        chk_val("value", 16'h1234, {hi_b, lo_b});
        chk_bit("flag", 1'b1, flag);
        chk_bit("irq", 1'b1, irq);
        set_timer(1'b1, 16'h5678);
        pad_to(1'b0);
        chk_val("value", 16'h1234, {hi_b, lo_b});
        pad_to(1'b1);
        chk_val("value", 16'h5678, {hi_b, lo_b});
        chk_bit("flag", 1'b1, flag);
        clr_flag();
        chk_bit("flag", 1'b0, flag);
        wr_ctrl(MODE_OFF);
        wr_ctrl(MODE_CAP_FALL);
        clr_flag();
        set_timer(1'b1, 16'h0F0F);
        pad_to(1'b0);
        chk_val("value", 16'h0F0F, {hi_b, lo_b});
        chk_bit("flag", 1'b1, flag);
        // prescaled captures after a clean restart of the prescaler
        for (int p = 0; p < 2; p++) begin
            wr_ctrl(MODE_OFF);
            wr_ctrl(pre_mode[p]);
            clr_flag();
            set_timer(1'b1, 16'h4000 + 16'(pre_n[p]));
            repeat (pre_n[p] - 1) begin
                pad_to(1'b1);
                pad_to(1'b0);
            end
            chk_bit("flag", 1'b0, flag);
            pad_to(1'b1);
            chk_bit("flag", 1'b1, flag);
            chk_val("value", 16'h4000 + 16'(pre_n[p]), {hi_b, lo_b});
            pad_to(1'b0);
        end
        wr_ctrl(MODE_CAP_RISE);
        t3_async = 1'b1;
        clr_flag();
        pad_to(1'b1);
        chk_bit("flag", 1'b0, flag);
        pad_to(1'b0);
        t3_async = 1'b0;
        // compare on timer one with the pin driven
        tsel = TSEL_ALL_LOW;
        dir = 1'b0;
        port_latch = 1'b1;
        wr_ctrl(MODE_OFF);
        chk_bit("pin_oe_n", 1'b0, oe_n);
        wr_val(16'h0321);
        wr_ctrl(MODE_CMP_SET_LOW);
        wr_ctrl(MODE_OFF);
        wr_ctrl(MODE_CMP_TOGGLE);
        chk_bit("pin_data_out", 1'b0, pin_out);
        clr_flag();
        cmp_hit(16'h0321);
        chk_bit("flag", 1'b1, flag);
        chk_bit("pin_data_out", 1'b1, pin_out);
        cmp_hit(16'h0321);
        chk_bit("pin_data_out", 1'b0, pin_out);
        for (int j = 0; j < 2; j++) begin
            wr_ctrl(cmp_mode[j]);
            chk_bit("pin_data_out", j[0], pin_out);
            clr_flag();
            cmp_hit(16'h0321);
            chk_bit("flag", 1'b1, flag);
            chk_bit("pin_data_out", !j[0], pin_out);
        end
        wr_ctrl(MODE_CMP_SET_HIGH);
        clr_flag();
        t1_async = 1'b1;
        cmp_hit(16'h0321);
        chk_bit("flag", 1'b0, flag);
        chk_bit("pin_data_out", 1'b0, pin_out);
        t1_async = 1'b0;
        // software interrupt mode leaves the pin on the port latch
        wr_ctrl(MODE_CMP_SOFT_IRQ);
        clr_flag();
        irq_en = 1'b0;
        port_latch = 1'b0;
        cmp_hit(16'h0321);
        chk_bit("flag", 1'b1, flag);
        chk_bit("pin_data_out", 1'b0, pin_out);
        chk_bit("irq", 1'b0, irq);
        irq_en = 1'b1;
        port_latch = 1'b1;
        tick(2);
        chk_bit("irq", 1'b1, irq);
        chk_bit("pin_data_out", 1'b1, pin_out);
        wr_ctrl(MODE_CMP_SPECIAL);
        clr_flag();
        set_timer(1'b0, 16'h0321);
        tick(2);
        chk_val("timer one", 16'h0000, t1_count);
        chk_val("timer three", 16'h4010, t3_count);
        chk_bit("flag", 1'b1, flag);
        give_verdict();
    end
endmodule
`default_nettype wire
